// ---- verilog/sirc_top.sv ----
// Serial number mirror, reset combiner and pull-up connect control
//
// Overview of operation
// - Lower five bytes of the 64-bit die serial each get a register.
// - Serial registers are read-only; contents come from the die id.
// - Serial registers load after power-up reset; USB reset leaves them.
// - Serial bytes decode ascending, byte 4 highest, one apart.
// - Register bits 7..0 carry serial bits 8n+7..8n, msb first.
// - Internal reset asserts when power-up reset or enabled USB reset asserts.
// - USB reset counts only with its enable set; enable resets to 0.
// - USB and global control registers clear on power-up reset only.
// - Connect bit one drives the pull-up pin high: hub sees a device.
// - Connect bit zero drives the pull-up pin low: hub sees nothing.
// - Connect is bit 7 of the USB control register, reset to zero.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns

`include "sirc_regs.svh"

module sirc_top
    import sirc_pkg::*;
(
    input  logic                    clk_sys,
    input  logic                    nrst,
    input  logic [39:0]             die_id,
    input  logic                    usb_function_reset_n,
    output logic                    internal_reset_n,
    output logic                    pullup_drive_pin,
    input  logic [`SIRC_ADDR_W-1:0] s_axi_awaddr,
    input  logic                    s_axi_awvalid,
    output logic                    s_axi_awready,
    input  logic [31:0]             s_axi_wdata,
    input  logic [3:0]              s_axi_wstrb,
    input  logic                    s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  logic                    s_axi_bready,
    input  logic [`SIRC_ADDR_W-1:0] s_axi_araddr,
    input  logic                    s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  logic                    s_axi_rready
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic reg_hit
    (
        input logic [`SIRC_ADDR_W-1:0] addr,
        input logic [15:0]             idx
    );
        reg_hit = (addr[`SIRC_ADDR_W-1:2] == idx);
    endfunction : reg_hit

    function automatic logic sn_hit
    (
        input logic [`SIRC_ADDR_W-1:0] addr
    );
        sn_hit = 1'b0;
        for (int i = 0; i < `SIRC_SN_BYTES; i++)
        begin
            if (reg_hit(addr, `SIRC_SN0_IDX + 16'(i)))
            begin
                sn_hit = 1'b1;
            end
        end
    endfunction : sn_hit

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [39:0]    die_meta_q;
    logic [39:0]    die_sync_q;
    logic           usb_function_reset_meta_q;
    logic           usb_function_reset_sync_q;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            die_meta_q  <= 40'h0;
            die_sync_q  <= 40'h0;
            usb_function_reset_meta_q <= 1'b0;
            usb_function_reset_sync_q <= 1'b0;
        end
        else
        begin
            die_meta_q  <= die_id;
            die_sync_q  <= die_meta_q;
            usb_function_reset_meta_q <= ~usb_function_reset_n;
            usb_function_reset_sync_q <= usb_function_reset_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Serial number capture
    // ------------------------------------------------------------
    // The identifier is caught once after power-up release, once the
    // synchroniser holds it; the USB reset never reaches this state.
    sirc_ld_state_t ld_state_q;
    sirc_ld_state_t ld_state_d;
    logic           sn_capture;
    logic [7:0]     sn_q [`SIRC_SN_BYTES];
    logic [7:0]     sn_d [`SIRC_SN_BYTES];

    always_comb
    begin
        ld_state_d = ld_state_q;
        sn_capture = 1'b0;
        case (ld_state_q)
            SIRC_LD_WAIT: ld_state_d = SIRC_LD_SYNC;
            SIRC_LD_SYNC: ld_state_d = SIRC_LD_CAPT;
            SIRC_LD_CAPT:
            begin
                sn_capture = 1'b1;
                ld_state_d = SIRC_LD_DONE;
            end
            SIRC_LD_DONE: ld_state_d = SIRC_LD_DONE;
            default:      ld_state_d = SIRC_LD_WAIT;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ld_state_q <= SIRC_LD_WAIT;
        end
        else
        begin
            ld_state_q <= ld_state_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `SIRC_SN_BYTES; g++)
        begin : g_sn
            // Only the die identifier feeds these bytes
            always_comb
            begin
                sn_d[g] = sn_q[g];
                if (sn_capture)
                begin
                    sn_d[g] = die_sync_q[8*g +: 8];
                end
            end

            always_ff @(posedge clk_sys or negedge nrst)
            begin
                if (!nrst)
                begin
                    sn_q[g] <= `SIRC_SN_RST;
                end
                else
                begin
                    sn_q[g] <= sn_d[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic                    aw_held_q;
    logic                    aw_held_d;
    logic [`SIRC_ADDR_W-1:0] aw_addr_q;
    logic [`SIRC_ADDR_W-1:0] aw_addr_d;
    logic                    w_held_q;
    logic                    w_held_d;
    logic [7:0]              w_byte_q;
    logic [7:0]              w_byte_d;
    logic                    w_lane_q;
    logic                    w_lane_d;
    logic                    bvalid_q;
    logic                    bvalid_d;
    logic [1:0]              bresp_q;
    logic [1:0]              bresp_d;
    sirc_ctrl_t              ctrl_q;
    sirc_ctrl_t              ctrl_d;
    logic                    commit;

    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready  = ~w_held_q & ~bvalid_q;
    assign commit        = aw_held_q & w_held_q;

    always_comb
    begin
        aw_held_d = aw_held_q;
        aw_addr_d = aw_addr_q;
        w_held_d  = w_held_q;
        w_byte_d  = w_byte_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        ctrl_d    = ctrl_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_d = 1'b1;
            w_byte_d = s_axi_wdata[7:0];
            w_lane_d = s_axi_wstrb[0];
        end
        if (commit)
        begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = `SIRC_RESP_DECERR;
            if (sn_hit(aw_addr_q))
            begin
                bresp_d = `SIRC_RESP_OKAY;
            end
            else if (reg_hit(aw_addr_q, `SIRC_USB_CONTROL_REGISTER_IDX))
            begin
                bresp_d = `SIRC_RESP_OKAY;
                if (w_lane_q)
                begin
                    ctrl_d.usb_control_register = w_byte_q & `SIRC_USB_CONTROL_REGISTER_MASK;
                end
            end
            else if (reg_hit(aw_addr_q, `SIRC_GLOBAL_CONTROL_REGISTER_IDX))
            begin
                bresp_d = `SIRC_RESP_OKAY;
                if (w_lane_q)
                begin
                    ctrl_d.global_control_register = w_byte_q & `SIRC_GLOBAL_CONTROL_REGISTER_MASK;
                end
            end
        end
        if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_held_q  <= 1'b0;
            w_byte_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `SIRC_RESP_OKAY;
        end
        else
        begin
            aw_held_q <= aw_held_d;
            aw_addr_q <= aw_addr_d;
            w_held_q  <= w_held_d;
            w_byte_q  <= w_byte_d;
            w_lane_q  <= w_lane_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    // Control registers see the power-up reset and nothing else, so
    // a USB reset cannot drop the pull-up or the reset enable.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q.usb_control_register  <= `SIRC_USB_CONTROL_REGISTER_RST;
            ctrl_q.global_control_register <= `SIRC_GLOBAL_CONTROL_REGISTER_RST;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic        rvalid_q;
    logic        rvalid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0]  rresp_q;
    logic [1:0]  rresp_d;

    assign s_axi_arready = ~rvalid_q;

    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_d = 1'b1;
            rdata_d  = 32'h0;
            rresp_d  = `SIRC_RESP_DECERR;
            for (int i = 0; i < `SIRC_SN_BYTES; i++)
            begin
                if (reg_hit(s_axi_araddr, `SIRC_SN0_IDX + 16'(i)))
                begin
                    rdata_d = {24'h0, sn_q[i]};
                    rresp_d = `SIRC_RESP_OKAY;
                end
            end
            if (reg_hit(s_axi_araddr, `SIRC_USB_CONTROL_REGISTER_IDX))
            begin
                rdata_d = {24'h0, ctrl_q.usb_control_register};
                rresp_d = `SIRC_RESP_OKAY;
            end
            if (reg_hit(s_axi_araddr, `SIRC_GLOBAL_CONTROL_REGISTER_IDX))
            begin
                rdata_d = {24'h0, ctrl_q.global_control_register};
                rresp_d = `SIRC_RESP_OKAY;
            end
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= `SIRC_RESP_OKAY;
        end
        else
        begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // ------------------------------------------------------------
    // Internal reset and pull-up drive
    // ------------------------------------------------------------
    logic int_ok_q;
    logic int_ok_d;
    logic pur_q;
    logic pur_d;

    always_comb
    begin
        // USB reset is gated by its enable bit
        int_ok_d = ~(ctrl_q.usb_control_register[`SIRC_FUNCTION_RESET_ENABLE_BIT] & usb_function_reset_sync_q);
        // Pin follows the bit one cycle later; a clear then set re-enumerates
        pur_d = ctrl_q.usb_control_register[`SIRC_CONNECT_BIT];
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            int_ok_q <= 1'b0;
            pur_q    <= 1'b0;
        end
        else
        begin
            int_ok_q <= int_ok_d;
            pur_q    <= pur_d;
        end
    end

    // Power-up reset acts without the clock; the USB term is registered
    assign internal_reset_n = nrst & int_ok_q;
    assign pullup_drive_pin = pur_q;

endmodule : sirc_top

// ---- verilog/sirc_regs.svh ----
// Register indices, field positions, reset values and counts
`ifndef SIRC_REGS_SVH
`define SIRC_REGS_SVH

// Register indices; the byte address is four times the index
`define SIRC_SN0_IDX      16'hffe8
`define SIRC_SN1_IDX      16'hffe9
`define SIRC_SN2_IDX      16'hffea
`define SIRC_SN3_IDX      16'hffeb
`define SIRC_SN4_IDX      16'hffec
`define SIRC_USB_CONTROL_REGISTER_IDX   16'hfff0
`define SIRC_GLOBAL_CONTROL_REGISTER_IDX  16'hfff1

`define SIRC_SN_BYTES     5
`define SIRC_ADDR_W       18

// Control fields
`define SIRC_CONNECT_BIT  7
`define SIRC_FUNCTION_RESET_ENABLE_BIT    4
`define SIRC_USB_CONTROL_REGISTER_MASK  8'h90
`define SIRC_GLOBAL_CONTROL_REGISTER_MASK 8'hff
`define SIRC_USB_CONTROL_REGISTER_RST   8'h00
`define SIRC_GLOBAL_CONTROL_REGISTER_RST  8'h00
`define SIRC_SN_RST       8'h00

// Bus answers
`define SIRC_RESP_OKAY    2'b00
`define SIRC_RESP_DECERR  2'b11

`endif

// ---- verilog/sirc_pkg.sv ----
// Types shared by the serial id, reset and connect block
package sirc_pkg;

    typedef enum logic [1:0] {
        SIRC_LD_WAIT,
        SIRC_LD_SYNC,
        SIRC_LD_CAPT,
        SIRC_LD_DONE
    } sirc_ld_state_t;

    typedef struct packed {
        logic [7:0] usb_control_register;
        logic [7:0] global_control_register;
    } sirc_ctrl_t;

endpackage : sirc_pkg

// ---- verif/sirc_top_chk.sv ----
// Port-level assertion checker for the serial id and connect block
`timescale 1ns/1ns
`include "sirc_regs.svh"
module sirc_top_chk (
    input logic                    clk_sys,
    input logic                    nrst,
    input logic [39:0]             die_id,
    input logic                    usb_function_reset_n,
    input logic                    internal_reset_n,
    input logic                    pullup_drive_pin,
    input logic [`SIRC_ADDR_W-1:0] s_axi_awaddr,
    input logic                    s_axi_awvalid,
    input logic                    s_axi_awready,
    input logic [31:0]             s_axi_wdata,
    input logic [3:0]              s_axi_wstrb,
    input logic                    s_axi_wvalid,
    input logic                    s_axi_wready,
    input logic [1:0]              s_axi_bresp,
    input logic                    s_axi_bvalid,
    input logic [`SIRC_ADDR_W-1:0] s_axi_araddr,
    input logic                    s_axi_arvalid,
    input logic                    s_axi_arready,
    input logic [31:0]             s_axi_rdata,
    input logic                    s_axi_rvalid
);
    localparam int SN0 = `SIRC_SN0_IDX;
    localparam int SN4 = `SIRC_SN4_IDX;
    localparam int USB = `SIRC_USB_CONTROL_REGISTER_IDX;
    localparam int GLB = `SIRC_GLOBAL_CONTROL_REGISTER_IDX;
    logic [17:0] awa_q, awa_d, ara_q, ara_d;
    logic [7:0]  wd_q, wd_d;
    logic [2:0]  up_q, up_d;
    logic        ws_q, ws_d, bv_q, conn_q, conn_d, fr_q, fr_d;

    function automatic logic mapd(input logic [17:0] a);
        return (a[17:2] >= SN0 && a[17:2] <= SN4) || a[17:2] == USB
            || a[17:2] == GLB;
    endfunction : mapd

    // --------------------------------------------------------------
    // Shadow of the control bits, taken one edge after bvalid rises
    // --------------------------------------------------------------
    always_comb
    begin
        awa_d = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awa_q;
        ara_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ara_q;
        wd_d = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[7:0] : wd_q;
        ws_d = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : ws_q;
        up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
        conn_d = conn_q;
        fr_d = fr_q;
        if (s_axi_bvalid && !bv_q && ws_q && awa_q[17:2] == USB)
        begin
            conn_d = wd_q[`SIRC_CONNECT_BIT];
            fr_d = wd_q[`SIRC_FUNCTION_RESET_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            {awa_q, ara_q, wd_q, up_q} <= '0;
            {ws_q, bv_q, conn_q, fr_q} <= '0;
        end
        else
        begin
            {awa_q, ara_q, wd_q, up_q} <= {awa_d, ara_d, wd_d, up_d};
            {ws_q, bv_q, conn_q, fr_q} <= {ws_d, s_axi_bvalid, conn_d, fr_d};
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    property p_rst;
        $rose(nrst) |-> !internal_reset_n && !pullup_drive_pin;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not low at reset release");
    property p_usb;
        (fr_q && !usb_function_reset_n)[*3] |=> !internal_reset_n;
    endproperty
    a_usb: assert property (p_usb)
        else $error("enabled usb reset did not reach internal reset");
    property p_gate;
        up_q >= 3'h2 && !fr_q && !$past(fr_q, 3) |-> internal_reset_n;
    endproperty
    a_gate: assert property (p_gate)
        else $error("internal reset low with function reset disabled");
    property p_pin;
        pullup_drive_pin == conn_q;
    endproperty
    a_pin: assert property (p_pin)
        else $error("pull-up pin differs from connect bit");
    property p_ctl;
        $rose(s_axi_rvalid) && ara_q[17:2] == USB
            |-> s_axi_rdata == {24'h0, conn_q, 2'h0, fr_q, 4'h0};
    endproperty
    a_ctl: assert property (p_ctl)
        else $error("usb control read value wrong");
    property p_sn;
        $rose(s_axi_rvalid) && up_q == 3'h7 && ara_q[17:2] >= SN0
            && ara_q[17:2] <= SN4
            |-> s_axi_rdata == {24'h0, die_id[8*ara_q[4:2] +: 8]};
    endproperty
    a_sn: assert property (p_sn)
        else $error("serial byte read value wrong");
    property p_bresp;
        $rose(s_axi_bvalid) |-> s_axi_bresp ==
            (mapd(awa_q) ? `SIRC_RESP_OKAY : `SIRC_RESP_DECERR);
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response code wrong");
    property p_rlat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rlat: assert property (p_rlat)
        else $error("read answer late");
    property p_arblk;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_arblk: assert property (p_arblk)
        else $error("read address taken while answer pending");
    property p_awblk;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_awblk: assert property (p_awblk)
        else $error("write taken while response pending");

    c_sn: cover property ($rose(s_axi_rvalid) && ara_q[17:2] == SN4);
    c_usb: cover property (fr_q && !internal_reset_n);
    c_conn: cover property ($rose(pullup_drive_pin));
endmodule : sirc_top_chk

bind sirc_top sirc_top_chk i_chk (.*);

// ---- verif/sirc_hub_model.sv ----
// Upstream hub model: senses the pull-up, drives the function reset
`timescale 1ns/1ns
module sirc_hub_model (
    input  wire logic clk_sys,
    input  wire logic pullup_drive_pin,
    output logic      usb_function_reset_n
);
    int attach_cnt;

    initial
    begin
        usb_function_reset_n = 1'b1;
        attach_cnt = 0;
    end

    // Each rising pull-up is a fresh attach, as a hub would count it
    always @(posedge pullup_drive_pin)
        attach_cnt++;

    task automatic bus_reset(input int n);
        @(posedge clk_sys);
        usb_function_reset_n <= 1'b0;
        repeat (n) @(posedge clk_sys);
        usb_function_reset_n <= 1'b1;
    endtask : bus_reset
endmodule : sirc_hub_model

// ---- verif/sirc_top_tb_top.sv ----
// Self-checking testbench for the serial id and connect block
`timescale 1ns/1ns
`include "sirc_regs.svh"
module sirc_top_tb_top;
    localparam int SN0 = `SIRC_SN0_IDX;
    localparam int USB = `SIRC_USB_CONTROL_REGISTER_IDX;
    localparam int GLB = `SIRC_GLOBAL_CONTROL_REGISTER_IDX;
    logic        clk_sys, nrst, usb_function_reset_n;
    logic        internal_reset_n, pullup_drive_pin;
    logic [39:0] die_id;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [63:0] rnd;
    int          err_total, n_checks, cyc, ctl, glob;
    int          sn[$];

    sirc_top i_dut (.*);
    sirc_hub_model i_hub (
        .clk_sys              (clk_sys),
        .pullup_drive_pin     (pullup_drive_pin),
        .usb_function_reset_n (usb_function_reset_n)
    );

    always #25 clk_sys = ~clk_sys;

    // ----------------------------------------------------------
    // Model, comparison and bus tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [33:0] mdl(input int i);
        if (i >= SN0 && i < SN0 + 5)
            return {2'h0, 32'(sn[i - SN0])};
        if (i == USB)
            return {2'h0, 32'(ctl)};
        if (i == GLB)
            return {2'h0, 32'(glob)};
        return {`SIRC_RESP_DECERR, 32'h0};
    endfunction : mdl

    task automatic wr(input int i, input int d);
        logic aw, w, b;
        logic [1:0] r;
        logic [33:0] e;
        b = 0;
        @(posedge clk_sys);
        rnd = {$urandom(), $urandom()};
        s_axi_awaddr <= {i[15:0], 2'h0};
        s_axi_wdata <= {rnd[31:8], d[7:0]};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b)
        begin
            @(negedge clk_sys);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk_sys);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        e = mdl(i);
        chk({r, 32'h0}, {e[33:32], 32'h0});
        if (i == USB && s_axi_wstrb[0]) ctl = d & 'h90;
        if (i == GLB && s_axi_wstrb[0]) glob = d & 'hff;
    endtask : wr

    task automatic rd(input int i);
        logic a, v;
        logic [33:0] got;
        v = 0;
        @(posedge clk_sys);
        s_axi_araddr <= {i[15:0], 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!v)
        begin
            @(negedge clk_sys);
            a = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            got = {s_axi_rresp, s_axi_rdata};
            @(posedge clk_sys);
            if (a) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk(got, mdl(i));
    endtask : rd

    task automatic pin_chk(input logic exp);
        @(negedge clk_sys);
        chk({33'h0, pullup_drive_pin}, {33'h0, exp});
    endtask : pin_chk

    // Hub holds its reset six cycles; sampled mid-pulse and after
    task automatic usb_rst(input logic exp);
        fork
            i_hub.bus_reset(6);
            begin
                repeat (5) @(posedge clk_sys);
                #1 chk({33'h0, internal_reset_n}, {33'h0, exp});
            end
        join
        repeat (4) @(posedge clk_sys);
        #1 chk({33'h0, internal_reset_n}, 34'h1);
    endtask : usb_rst

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            finish_test();
        end
    end

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial
    begin
        rnd = 64'($urandom(47));
        rnd = {$urandom(), $urandom()};
        {clk_sys, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        die_id = rnd[39:0];
        for (int n = 0; n < 5; n++)
            sn.push_back(int'(die_id[8*n +: 8]));
        {ctl, glob, err_total, n_checks, cyc} = '0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(USB);
        rd(GLB);
        pin_chk(1'b0);
        repeat (4) @(posedge clk_sys);
        for (int n = SN0; n < SN0 + 5; n++)
        begin
            rd(n);
            wr(n, $urandom());
            rd(n);
        end
        wr(SN0 - 1, 'h5a);
        rd(SN0 + 5);
        rd(USB + 2);
        // Odd passes drop lane 0, so that write must leave the value alone
        for (int k = 0; k < 4; k++)
        begin
            s_axi_wstrb <= 4'hf ^ 4'(k[0]);
            wr(GLB, $urandom());
            rd(GLB);
        end
        s_axi_wstrb <= 4'hf;
        for (int k = 0; k < 2; k++)
        begin
            wr(USB, 'h00);
            pin_chk(1'b0);
            wr(USB, 'h80);
            pin_chk(1'b1);
        end
        chk(34'(i_hub.attach_cnt), 34'h2);
        usb_rst(1'b1);
        wr(USB, 'h90);
        usb_rst(1'b0);
        rd(USB);
        rd(GLB);
        rd(SN0 + 3);
        @(posedge clk_sys);
        nrst <= 1'b0;
        @(negedge clk_sys);
        chk({32'h0, internal_reset_n, pullup_drive_pin}, 34'h0);
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        {ctl, glob} = '0;
        rd(USB);
        rd(GLB);
        repeat (4) @(posedge clk_sys);
        rd(SN0 + 4);
        finish_test();
    end
endmodule : sirc_top_tb_top
